// ===== pkg/lccr_pkg.sv
package lccr_pkg;

	// Command codes of the two configuration registers.
	localparam logic [7:0] LCCR_ALT_CMD  = 8'hAC;
	localparam logic [7:0] LCCR_LOOP_CMD = 8'hAD;

	// Values held before the nonvolatile restore has run.
	localparam logic [7:0] LCCR_ALT_RST  = 8'h00;
	localparam logic [6:0] LCCR_LOOP_RST = 7'h00;
	localparam logic [7:0] LCCR_RD_RST   = 8'h00;

	// Field positions of the alternate integrator and ramp register.
	localparam int LCCR_GAIN_MSB = 7;
	localparam int LCCR_GAIN_LSB = 6;
	localparam int LCCR_TIME_MSB = 5;
	localparam int LCCR_TIME_LSB = 3;
	localparam int LCCR_RAMP_MSB = 2;
	localparam int LCCR_RAMP_LSB = 0;

	// Field positions of the loop mode, sense and load-line register.
	localparam int LCCR_RSVD_BIT = 7;
	localparam int LCCR_SSDCM_BIT = 6;
	localparam int LCCR_NEG_BIT  = 5;
	localparam int LCCR_IND_MSB  = 4;
	localparam int LCCR_IND_LSB  = 3;
	localparam int LCCR_LL_MSB   = 2;
	localparam int LCCR_LL_LSB   = 0;

	// Integrator gain in halves: 2, 1.5, 1 and 0.5.
	localparam logic [2:0] LCCR_GAIN_TBL [4] = '{
		3'h4, 3'h3, 3'h2, 3'h1
	};
	// Integrator time constant in units of 10 ns.
	localparam logic [10:0] LCCR_TIME_TBL [8] = '{
		11'h019, 11'h064, 11'h12C, 11'h1C2,
		11'h271, 11'h320, 11'h3E8, 11'h7D0
	};
	// Ramp amplitude in millivolts.
	localparam logic [7:0] LCCR_RAMP_TBL [8] = '{
		8'h28, 8'h3C, 8'h50, 8'h64, 8'h78, 8'hA0, 8'hC8, 8'hF0
	};
	// Sense inductance in nanohenries.
	localparam logic [8:0] LCCR_IND_TBL [4] = '{
		9'h064, 9'h0C8, 9'h12C, 9'h190
	};
	// DC load line in micro-ohms.
	localparam logic [11:0] LCCR_LL_TBL [8] = '{
		12'h000, 12'h1F4, 12'h2EE, 12'h3E8,
		12'h5DC, 12'hB54, 12'hC80, 12'hFD2
	};

endpackage

// ===== sim/lccr_host_model.sv
module lccr_host_model (
	// Clock.
	input  wire logic       clk,
	// Command port toward the register block.
	output logic      [7:0] cmd_code,
	output logic            wr_stb,
	output logic      [7:0] wr_data,
	output logic            rd_stb,
	input  wire logic [7:0] rd_data,
	input  wire logic       rd_ack,
	input  wire logic       rd_unmapped
);
	timeunit 1ns;
	timeprecision 1ps;

	// Idle bus until the first transfer.
	initial begin
		cmd_code = 8'h00;
		wr_stb = 1'b0;
		wr_data = 8'h00;
		rd_stb = 1'b0;
	end

	// One byte per write; released lines flip so stale values never match.
	task automatic wr(input logic [7:0] cmd, input logic [7:0] data);
		@(negedge clk);
		cmd_code = cmd;
		wr_data = data;
		wr_stb = 1'b1;
		@(negedge clk);
		wr_stb = 1'b0;
		wr_data = ~data;
		cmd_code = ~cmd;
	endtask

	// Write, then read the same register in the very next cycle.
	task automatic wrrd(input logic [7:0] cmd, input logic [7:0] data,
		output logic [7:0] rdat, output logic ack, output logic unm);
		@(negedge clk);
		cmd_code = cmd;
		wr_data = data;
		wr_stb = 1'b1;
		@(negedge clk);
		wr_stb = 1'b0;
		wr_data = ~data;
		rd_stb = 1'b1;
		@(negedge clk);
		rdat = rd_data;
		ack = rd_ack;
		unm = rd_unmapped;
		rd_stb = 1'b0;
		cmd_code = ~cmd;
	endtask

	// One byte per read; the answer is taken one cycle after the strobe.
	task automatic rd(input logic [7:0] cmd, output logic [7:0] data,
		output logic ack, output logic unm);
		@(negedge clk);
		cmd_code = cmd;
		rd_stb = 1'b1;
		@(negedge clk);
		data = rd_data;
		ack = rd_ack;
		unm = rd_unmapped;
		rd_stb = 1'b0;
		cmd_code = ~cmd;
	endtask
endmodule // lccr_host_model

// ===== sim/lccr_regs_test.sv
module lccr_regs_test
	import lccr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic CLK, RST, WR_STB, RD_STB, RD_ACK, RD_UNMAPPED, NVM_LOAD;
	logic SS_ACTIVE, CCM_CFG, DCM_MODE, NEG_SHORT_ON;
	logic [7:0] CMD_CODE, WR_DATA, RD_DATA, NVM_ALT_DATA, NVM_LOOP_DATA;
	logic [8:0] SENSE_IND_NH;
	logic [11:0] LOAD_LINE_UOHM;
	logic [2:0] ALT_GAIN_HALVES;
	logic [10:0] ALT_TIME_10NS;
	logic [7:0] ALT_RAMP_MV;
	int bad_count = 0;
	int checks_done = 0;
	int cycles = 0;
	// Expected decodes in 10 ns, mV and micro-ohm, kept apart from the design.
	logic [11:0] time_tbl [8] = '{12'h019, 12'h064, 12'h12C, 12'h1C2,
		12'h271, 12'h320, 12'h3E8, 12'h7D0};
	logic [11:0] ramp_tbl [8] = '{12'h028, 12'h03C, 12'h050, 12'h064,
		12'h078, 12'h0A0, 12'h0C8, 12'h0F0};
	logic [11:0] ll_tbl [8] = '{12'h000, 12'h1F4, 12'h2EE, 12'h3E8,
		12'h5DC, 12'hB54, 12'hC80, 12'hFD2};

	lccr_regs lccr_regs_i (.CLK(CLK), .RST(RST), .CMD_CODE(CMD_CODE),
		.WR_STB(WR_STB), .WR_DATA(WR_DATA), .RD_STB(RD_STB),
		.RD_DATA(RD_DATA), .RD_ACK(RD_ACK), .RD_UNMAPPED(RD_UNMAPPED),
		.NVM_LOAD(NVM_LOAD), .NVM_ALT_DATA(NVM_ALT_DATA),
		.NVM_LOOP_DATA(NVM_LOOP_DATA), .SS_ACTIVE(SS_ACTIVE),
		.CCM_CFG(CCM_CFG), .DCM_MODE(DCM_MODE),
		.NEG_SHORT_ON(NEG_SHORT_ON), .SENSE_IND_NH(SENSE_IND_NH),
		.LOAD_LINE_UOHM(LOAD_LINE_UOHM), .ALT_GAIN_HALVES(ALT_GAIN_HALVES),
		.ALT_TIME_10NS(ALT_TIME_10NS), .ALT_RAMP_MV(ALT_RAMP_MV));
	lccr_host_model lccr_host_model_i (.clk(CLK), .cmd_code(CMD_CODE),
		.wr_stb(WR_STB), .wr_data(WR_DATA), .rd_stb(RD_STB),
		.rd_data(RD_DATA), .rd_ack(RD_ACK), .rd_unmapped(RD_UNMAPPED));

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
		checks_done++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// A read must be answered, flagged only when unmapped.
	task automatic rdchk(input logic [7:0] cmd, input logic [7:0] exp,
		input logic unm);
		logic [7:0] d;
		logic a, u;
		lccr_host_model_i.rd(cmd, d, a, u);
		chk(d, exp);
		chk(a, 1'b1);
		chk(u, unm);
	endtask

	// Back-to-back write and read, so the read sees the new byte at once.
	task automatic wrrdchk(input logic [7:0] cmd, input logic [7:0] v,
		input logic [7:0] exp);
		logic [7:0] d;
		logic a, u;
		lccr_host_model_i.wrrd(cmd, v, d, a, u);
		chk(d, exp);
		chk(a, 1'b1);
		chk(u, 1'b0);
	endtask

	task automatic t_reset();
		chk(DCM_MODE, 1'b1);
		chk(SENSE_IND_NH, 12'h064);
		chk(ALT_TIME_10NS, 12'h019);
		rdchk(LCCR_ALT_CMD, 8'h00, 1'b0);
		rdchk(LCCR_LOOP_CMD, 8'h00, 1'b0);
	endtask

	// Restore all ones; the reserved bit must not survive.
	task automatic t_restore();
		NVM_ALT_DATA = 8'hFF;
		NVM_LOOP_DATA = 8'hFF;
		NVM_LOAD = 1'b1;
		@(negedge CLK);
		NVM_LOAD = 1'b0;
		chk(ALT_GAIN_HALVES, 12'h001);
		chk(LOAD_LINE_UOHM, 12'hFD2);
		rdchk(LCCR_ALT_CMD, 8'hFF, 1'b0);
		rdchk(LCCR_LOOP_CMD, 8'h7F, 1'b0);
	endtask

	// Every alternate code decodes, reads back and leaves sense inductance and load line unchanged.
	task automatic t_alt();
		logic [2:0] c;
		logic [7:0] v;
		for (int i = 0; i < 8; i++) begin
			c = i[2:0];
			v = {c[1:0], c, c};
			wrrdchk(LCCR_ALT_CMD, v, v);
			chk(ALT_GAIN_HALVES, 12'h004 - c[1:0]);
			chk(ALT_TIME_10NS, time_tbl[c]);
			chk(ALT_RAMP_MV, ramp_tbl[c]);
		end
		chk(LOAD_LINE_UOHM, 12'hFD2);
		chk(SENSE_IND_NH, 12'h190);
	endtask

	// Bit 7 is always written as one and must read back zero.
	task automatic t_loop();
		logic [2:0] c;
		logic [7:0] v;
		for (int i = 0; i < 8; i++) begin
			c = i[2:0];
			v = {2'h2, c[0], c[1:0], c};
			wrrdchk(LCCR_LOOP_CMD, v, {1'b0, v[6:0]});
			chk(NEG_SHORT_ON, c[0]);
			chk(SENSE_IND_NH, 12'h064 * (c[1:0] + 12'h001));
			chk(LOAD_LINE_UOHM, ll_tbl[c]);
		end
	endtask

	// All soft-start, force bit and continuous setting combinations.
	task automatic t_mode();
		logic [2:0] c;
		logic e;
		for (int i = 0; i < 8; i++) begin
			c = i[2:0];
			lccr_host_model_i.wr(LCCR_LOOP_CMD, {1'b0, c[1], 6'h00});
			SS_ACTIVE = c[2];
			CCM_CFG = c[0];
			e = (c[2] & c[1]) | ~c[0];
			@(negedge CLK);
			chk(DCM_MODE, e);
		end
	endtask

	// An unmapped write changes nothing; its read is flagged.
	task automatic t_unmapped();
		lccr_host_model_i.wr(8'hAE, 8'h55);
		rdchk(8'hAE, 8'h00, 1'b1);
		rdchk(LCCR_ALT_CMD, 8'hFF, 1'b0);
		rdchk(LCCR_LOOP_CMD, 8'h40, 1'b0);
	endtask

	initial begin
		CLK = 1'b0;
		forever #2 CLK = ~CLK;
	end

	// Cut a hang short well past the hundred or so cycles the run needs.
	always @(posedge CLK) begin
		cycles++;
		if (cycles == 3000) begin
			bad_count++;
			report_and_stop();
		end
	end

	initial begin
		RST = 1'b1;
		NVM_LOAD = 1'b0;
		NVM_ALT_DATA = 8'h00;
		NVM_LOOP_DATA = 8'h00;
		SS_ACTIVE = 1'b0;
		CCM_CFG = 1'b0;
		repeat (8) @(negedge CLK);
		RST = 1'b0;
		t_reset();
		t_restore();
		t_alt();
		t_loop();
		t_mode();
		t_unmapped();
		// A second reset mid-run must bring every register back.
		RST = 1'b1;
		repeat (2) @(negedge CLK);
		RST = 1'b0;
		t_reset();
		report_and_stop();
	end
endmodule // lccr_regs_test

// ===== verilog/lccr_field_decode.sv
module lccr_field_decode
	import lccr_pkg::*;
(
	// Raw register contents.
	input  wire logic [7:0]  alt_cfg,
	input  wire logic [6:0]  loop_cfg,
	// Decoded alternate settings.
	output logic      [2:0]  gain_halves,
	output logic      [10:0] time_10ns,
	output logic      [7:0]  ramp_mv,
	// Decoded loop settings.
	output logic      [8:0]  ind_nh,
	output logic      [11:0] ll_uohm
);

	// Pure table lookups; the caller registers the results.
	always_comb begin
		gain_halves = LCCR_GAIN_TBL[alt_cfg[LCCR_GAIN_MSB:LCCR_GAIN_LSB]];
		time_10ns   = LCCR_TIME_TBL[alt_cfg[LCCR_TIME_MSB:LCCR_TIME_LSB]];
		ramp_mv     = LCCR_RAMP_TBL[alt_cfg[LCCR_RAMP_MSB:LCCR_RAMP_LSB]];
		ind_nh      = LCCR_IND_TBL[loop_cfg[LCCR_IND_MSB:LCCR_IND_LSB]];
		ll_uohm     = LCCR_LL_TBL[loop_cfg[LCCR_LL_MSB:LCCR_LL_LSB]];
	end

endmodule // lccr_field_decode

// ===== verilog/lccr_regs.sv
// Behaviour
// RL1 - Alternate register is plain read/write storage that steers nothing.
// RL2 - Alternate gain bits 7:6 mean 2, 1.5, 1, 0.5.
// RL3 - Alternate time bits 5:3 mean 0.25 to 20 us, eight steps.
// RL4 - Alternate ramp bits 2:0 mean 40 to 240 mV, eight steps.
// RL5 - Each register moves as one unsigned byte per write or read.
// RL6 - Fields load from nonvolatile storage; writes apply at once.
// RL7 - Loop register bit 7 is read-only and reads zero.
// RL8 - In soft-start, bit 6 forces discontinuous mode; 0 keeps mode setting.
// RL9 - After soft-start bit 6 is ignored; mode setting alone decides.
// RL10 - Bit 5 picks short or long on-time for negative current limiting.
// RL11 - Bits 4:3 give sense inductance 100, 200, 300, 400 nH.
// RL12 - Software programs nearest inductance code, 11b above 400 nH.
// RL13 - Bits 2:0 give load line 0 to 4.05 milliohm.
// RL14 - Software chooses the load line the powered load requires.
// RL15 - Writes to loop register bit 7 are discarded; bit stays zero.
module lccr_regs
	import lccr_pkg::*;
(
	// Clock and reset.
	input  wire logic        CLK,
	input  wire logic        RST,
	// Command port from the serial interface engine.
	input  wire logic [7:0]  CMD_CODE,
	input  wire logic        WR_STB,
	input  wire logic [7:0]  WR_DATA,
	input  wire logic        RD_STB,
	output logic      [7:0]  RD_DATA,
	output logic             RD_ACK,
	output logic             RD_UNMAPPED,
	// Power-up restore from nonvolatile storage.
	input  wire logic        NVM_LOAD,
	input  wire logic [7:0]  NVM_ALT_DATA,
	input  wire logic [7:0]  NVM_LOOP_DATA,
	// Loop state from the power stage control.
	input  wire logic        SS_ACTIVE,
	input  wire logic        CCM_CFG,
	// Loop controls.
	output logic             DCM_MODE,
	output logic             NEG_SHORT_ON,
	output logic      [8:0]  SENSE_IND_NH,
	output logic      [11:0] LOAD_LINE_UOHM,
	// Alternate settings, informational only.
	output logic      [2:0]  ALT_GAIN_HALVES,
	output logic      [10:0] ALT_TIME_10NS,
	output logic      [7:0]  ALT_RAMP_MV
);

	typedef struct packed {
		logic [7:0]  alt;
		logic [6:0]  loop;
		logic        ss;
		logic        ccm;
		logic [7:0]  rd_data;
		logic        rd_ack;
		logic        rd_unm;
		logic        dcm;
		logic        neg_short;
		logic [8:0]  ind_nh;
		logic [11:0] ll_uohm;
		logic [2:0]  gain;
		logic [10:0] tconst;
		logic [7:0]  ramp;
	} lccr_state_s;

	lccr_state_s state_ff;
	lccr_state_s nxt_state;

	logic [2:0]  dec_gain;
	logic [10:0] dec_time;
	logic [7:0]  dec_ramp;
	logic [8:0]  dec_ind;
	logic [11:0] dec_ll;

	// Decode from the next contents so outputs line up with the registers.
	lccr_field_decode u_decode (
		.alt_cfg     (nxt_state.alt),
		.loop_cfg    (nxt_state.loop),
		.gain_halves (dec_gain),
		.time_10ns   (dec_time),
		.ramp_mv     (dec_ramp),
		.ind_nh      (dec_ind),
		.ll_uohm     (dec_ll)
	);

	// Next-state logic. The restore outranks a host write in the same
	// cycle, since it only runs at power-up before the host is live.
	always_comb begin
		nxt_state        = state_ff;
		nxt_state.rd_ack = 1'b0;
		nxt_state.rd_unm = 1'b0;
		nxt_state.ss     = SS_ACTIVE;
		nxt_state.ccm    = CCM_CFG;
		if (NVM_LOAD) begin
			nxt_state.alt  = NVM_ALT_DATA; // RL6
			nxt_state.loop = NVM_LOOP_DATA[6:0]; // RL6 RL15
		end else if (WR_STB) begin
			if (CMD_CODE == LCCR_ALT_CMD) begin
				nxt_state.alt = WR_DATA; // RL1 RL5
			end else if (CMD_CODE == LCCR_LOOP_CMD) begin
				nxt_state.loop = WR_DATA[6:0]; // RL5 RL15
			end
		end
		// Reads see the stored byte; the reserved bit is forced low.
		if (RD_STB) begin
			nxt_state.rd_ack = 1'b1; // RL5
			if (CMD_CODE == LCCR_ALT_CMD) begin
				nxt_state.rd_data = state_ff.alt;
			end else if (CMD_CODE == LCCR_LOOP_CMD) begin
				nxt_state.rd_data = {1'b0, state_ff.loop}; // RL7
			end else begin
				nxt_state.rd_data = LCCR_RD_RST;
				nxt_state.rd_unm  = 1'b1;
			end
		end
		// Soft-start may force discontinuous mode; afterwards only the
		// continuous-mode setting decides.
		if (SS_ACTIVE && nxt_state.loop[LCCR_SSDCM_BIT]) begin
			nxt_state.dcm = 1'b1; // RL8
		end else begin
			nxt_state.dcm = !CCM_CFG; // RL8 RL9
		end
		nxt_state.neg_short = nxt_state.loop[LCCR_NEG_BIT]; // RL10
		nxt_state.ind_nh    = dec_ind; // RL11
		nxt_state.ll_uohm   = dec_ll; // RL13
		// Alternate decode is exported for visibility only.
		nxt_state.gain      = dec_gain; // RL2
		nxt_state.tconst    = dec_time; // RL3
		nxt_state.ramp      = dec_ramp; // RL4
	end

	// State register; contents stay at reset values until restored or written.
	always_ff @(posedge CLK) begin
		if (RST) begin
			state_ff           <= '0;
			state_ff.alt       <= LCCR_ALT_RST;
			state_ff.loop      <= LCCR_LOOP_RST;
			state_ff.rd_data   <= LCCR_RD_RST;
			state_ff.dcm       <= 1'b1;
			state_ff.ind_nh    <= LCCR_IND_TBL[0];
			state_ff.ll_uohm   <= LCCR_LL_TBL[0];
			state_ff.gain      <= LCCR_GAIN_TBL[0];
			state_ff.tconst    <= LCCR_TIME_TBL[0];
			state_ff.ramp      <= LCCR_RAMP_TBL[0];
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Outputs straight from the state register.
	assign RD_DATA         = state_ff.rd_data;
	assign RD_ACK          = state_ff.rd_ack;
	assign RD_UNMAPPED     = state_ff.rd_unm;
	assign DCM_MODE        = state_ff.dcm;
	assign NEG_SHORT_ON    = state_ff.neg_short;
	assign SENSE_IND_NH    = state_ff.ind_nh;
	assign LOAD_LINE_UOHM  = state_ff.ll_uohm;
	assign ALT_GAIN_HALVES = state_ff.gain;
	assign ALT_TIME_10NS   = state_ff.tconst;
	assign ALT_RAMP_MV     = state_ff.ramp;

	// Checks on the register behaviour.
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);

	sequence seq_alt_write;
		WR_STB && !NVM_LOAD && CMD_CODE == LCCR_ALT_CMD;
	endsequence

	sequence seq_loop_write;
		WR_STB && !NVM_LOAD && CMD_CODE == LCCR_LOOP_CMD;
	endsequence

	sequence seq_loop_read;
		RD_STB && CMD_CODE == LCCR_LOOP_CMD;
	endsequence

	a_alt_store_read: assert property ( // RL1
		seq_alt_write ##1 (RD_STB && CMD_CODE == LCCR_ALT_CMD && !WR_STB)
		|=> RD_ACK && RD_DATA == $past(WR_DATA, 2))
		else $error("Alternate register did not read back written byte.");

	a_gain_decode: assert property ( // RL2
		state_ff.alt[7:6] == 2'b01 |-> ALT_GAIN_HALVES == 3'h3)
		else $error("Alternate gain code 01 not decoded as 1.5.");

	a_time_decode: assert property ( // RL3
		state_ff.alt[5:3] == 3'b111 |-> ALT_TIME_10NS == 11'h7D0)
		else $error("Alternate time code 111 not decoded as 20 us.");

	a_ramp_decode: assert property ( // RL4
		state_ff.alt[2:0] == 3'b000 |-> ALT_RAMP_MV == 8'h28)
		else $error("Alternate ramp code 000 not decoded as 40 mV.");

	a_read_one_byte: assert property ( // RL5
		RD_STB ##1 !RD_STB |-> RD_ACK ##1 !RD_ACK)
		else $error("Read acknowledge not a single cycle.");

	a_nvm_restore: assert property ( // RL6
		NVM_LOAD |=> state_ff.loop == $past(NVM_LOOP_DATA[6:0])
			&& state_ff.alt == $past(NVM_ALT_DATA))
		else $error("Restore did not load both registers.");

	a_rsvd_reads_zero: assert property ( // RL7
		seq_loop_read |=> RD_ACK && !RD_DATA[7])
		else $error("Reserved loop bit read as one.");

	a_ss_force_dcm: assert property ( // RL8
		state_ff.ss && state_ff.loop[6] |-> DCM_MODE)
		else $error("Soft-start did not force discontinuous mode.");

	a_after_ss_mode: assert property ( // RL9
		!state_ff.ss |-> DCM_MODE == !state_ff.ccm)
		else $error("Mode after soft-start ignores continuous setting.");

	a_noc_on_time: assert property ( // RL10
		seq_loop_write |=> NEG_SHORT_ON == $past(WR_DATA[5]))
		else $error("On-time select not applied at once.");

	a_ind_decode: assert property ( // RL11
		state_ff.loop[4:3] == 2'b11 |-> SENSE_IND_NH == 9'h190)
		else $error("Inductance code 11 not decoded as 400 nH.");

	a_ll_decode: assert property ( // RL13
		state_ff.loop[2:0] == 3'b101 |-> LOAD_LINE_UOHM == 12'hB54)
		else $error("Load line code 101 not decoded as 2.9 mOhm.");

	a_rsvd_discard: assert property ( // RL15
		seq_loop_write ##1 seq_loop_read |=> !RD_DATA[7]
			&& RD_DATA[6:0] == $past(WR_DATA[6:0], 2))
		else $error("Loop write not stored with bit 7 discarded.");

endmodule // lccr_regs
